// file: design/tdc_pkg.sv
package tdc_pkg;
  // ==========================================================
  // register map (printed offsets are not all multiples of 4)
  localparam logic [7:0]  TDC_IDX_CONFIG   = 8'h21;
  localparam logic [7:0]  TDC_IDX_SOURCE   = 8'h22;
  localparam logic [7:0]  TDC_IDX_LEVEL_X  = 8'h23;
  localparam logic [7:0]  TDC_IDX_LEVEL_Y  = 8'h24;
  localparam logic [7:0]  TDC_IDX_LEVEL_Z  = 8'h25;
  localparam logic [7:0]  TDC_IDX_LIMIT    = 8'h26;
  localparam logic [7:0]  TDC_IDX_LATENCY  = 8'h27;
  localparam logic [7:0]  TDC_IDX_WINDOW   = 8'h28;
  localparam logic [7:0]  TDC_IDX_CONTROL  = 8'h2a;
  localparam logic [7:0]  TDC_IDX_STEP     = 8'h30;
  // ==========================================================
  // config fields
  localparam int TDC_CFG_ABORT = 7;
  localparam int TDC_CFG_LATCH = 6;
  localparam int TDC_CFG_ZD    = 5;
  localparam int TDC_CFG_ZS    = 4;
  localparam int TDC_CFG_YD    = 3;
  localparam int TDC_CFG_YS    = 2;
  localparam int TDC_CFG_XD    = 1;
  localparam int TDC_CFG_XS    = 0;
  // source fields, and the low-noise bit of the control register
  localparam int TDC_SRC_ACTIVE = 7;
  localparam int TDC_SRC_SEEN0  = 4;
  localparam int TDC_SRC_DOUBLE = 3;
  localparam int TDC_SRC_SIGN0  = 0;
  localparam int TDC_CTL_LOW_NOISE = 2;
  // ==========================================================
  // reset values and scales
  localparam logic [7:0]  TDC_RST_BYTE   = 8'h00;
  localparam logic [6:0]  TDC_RST_LEVEL  = 7'h00;
  localparam logic [15:0] TDC_RST_STEP   = 16'h0064;
  // 8g scale over 7 bits: one level step is 1/16 of a g
  localparam int          TDC_SCALE_SHIFT = 4;
  // low noise: 4g ceiling is level 64
  localparam logic [6:0]  TDC_LEVEL_CAP_LN = 7'h40;

  typedef enum logic [1:0] {
    TDC_AXIS_X, TDC_AXIS_Y, TDC_AXIS_Z
  } tdc_axis_t;

  typedef struct packed {
    logic [2:0] seen;
    logic       double_tap;
    logic [2:0] sign;
  } tdc_event_t;
endpackage

// file: design/tdc_tap_detect.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Functional notes
// - abort bit clear: double tap keeps running
// - abort set: short pulse in latency suspends
// - latch bit selects latching of source flags
// - per-axis double tap enables, reset zero
// - per-axis single tap enables, reset zero
// - report only enabled axis and type
// - active flag set once event generated
// - per-axis seen flags in bits 6..4
// - bit 3 tells single or double
// - per-axis sign bits, one is negative
// - latched: freeze status until source read
// - source read clears all and interrupt
// - independent per-axis levels start detection
// - seven-bit level, bit 7 reads zero
// - fixed 8g scale, 0.063g per step
// - low noise caps level at 4g
// - level fields reset to zero
// - pulse valid if it ends within limit
// - ignore pulses during latency interval
// - second pulse starts within window
module tdc_tap_detect
  import tdc_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               sample_valid,
  input  wire logic signed [13:0] accel_x,
  input  wire logic signed [13:0] accel_y,
  input  wire logic signed [13:0] accel_z,
  output logic                    tap_irq
);
  import tdc_pkg::*;

  // ==========================================================
  // bus slave: zero wait states, always OKAY
  logic       ap_wr;
  logic       ap_rd;
  logic [7:0] ap_idx;
  logic       next_ap_wr;
  logic       next_ap_rd;
  logic [7:0] next_ap_idx;
  logic       req;

  assign req = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    next_ap_wr = req && hwrite;
    next_ap_rd = req && !hwrite;
    next_ap_idx = req ? haddr[9:2] : ap_idx;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_idx <= TDC_RST_BYTE;
    end else begin
      ap_wr <= next_ap_wr;
      ap_rd <= next_ap_rd;
      ap_idx <= next_ap_idx;
    end
  end

  // ==========================================================
  // software registers
  logic [7:0]  config_q;
  logic [6:0]  level [3];
  logic [7:0]  time_limit;
  logic [7:0]  latency;
  logic [7:0]  window;
  logic [7:0]  control;
  logic [15:0] step;
  logic [7:0]  next_config;
  logic [6:0]  next_level [3];
  logic [7:0]  next_time_limit;
  logic [7:0]  next_latency;
  logic [7:0]  next_window;
  logic [7:0]  next_control;
  logic [15:0] next_step;
  logic [7:0]  wbyte;

  assign wbyte = hwdata[7:0];

  always_comb begin
    next_config = config_q;
    next_level = level;
    next_time_limit = time_limit;
    next_latency = latency;
    next_window = window;
    next_control = control;
    next_step = step;
    if (ap_wr) begin
      unique case (ap_idx)
        TDC_IDX_CONFIG:  next_config = wbyte;
        TDC_IDX_LEVEL_X: next_level[TDC_AXIS_X] = wbyte[6:0];
        TDC_IDX_LEVEL_Y: next_level[TDC_AXIS_Y] = wbyte[6:0];
        TDC_IDX_LEVEL_Z: next_level[TDC_AXIS_Z] = wbyte[6:0];
        TDC_IDX_LIMIT:   next_time_limit = wbyte;
        TDC_IDX_LATENCY: next_latency = wbyte;
        TDC_IDX_WINDOW:  next_window = wbyte;
        TDC_IDX_CONTROL: next_control = wbyte;
        TDC_IDX_STEP:    next_step = hwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_q <= TDC_RST_BYTE;
      level[0] <= TDC_RST_LEVEL;
      level[1] <= TDC_RST_LEVEL;
      level[2] <= TDC_RST_LEVEL;
      time_limit <= TDC_RST_BYTE;
      latency <= TDC_RST_BYTE;
      window <= TDC_RST_BYTE;
      control <= TDC_RST_BYTE;
      step <= TDC_RST_STEP;
    end else begin
      config_q <= next_config;
      level <= next_level;
      time_limit <= next_time_limit;
      latency <= next_latency;
      window <= next_window;
      control <= next_control;
      step <= next_step;
    end
  end

  // ==========================================================
  // time step enable: timers advance once every step+1 cycles of hclk
  logic [15:0] div;
  logic [15:0] next_div;
  logic        tick;

  assign tick = (div == 16'h0000);
  always_comb begin
    next_div = tick ? step : div - 16'h0001;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= TDC_RST_STEP;
    end else begin
      div <= next_div;
    end
  end

  // ==========================================================
  // per-axis threshold compare on the fixed 8g scale
  function automatic logic [6:0] eff_level(input logic [6:0] lv,
                                           input logic       ln);
    eff_level = (ln && lv > TDC_LEVEL_CAP_LN) ? TDC_LEVEL_CAP_LN : lv;
  endfunction

  logic signed [13:0] acc [3];
  logic [2:0] above;
  logic [2:0] above_now;
  logic [2:0] above_held;
  logic [2:0] next_above_held;
  logic [2:0] neg;
  assign acc[0] = accel_x;
  assign acc[1] = accel_y;
  assign acc[2] = accel_z;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cmp
      logic [13:0] mag;
      assign mag = acc[g][13] ? 14'(-acc[g]) : 14'(acc[g]);
      // 14-bit count over +-8g: shift to 1/16 g units
      assign above_now[g] =
        ((mag >> (13 - TDC_SCALE_SHIFT - 3)) >
         {7'h00, eff_level(level[g], control[TDC_CTL_LOW_NOISE])});
      assign neg[g] = acc[g][13];
    end
  endgenerate

  // between samples the last result stands, or every pulse would end
  always_comb begin
    above = sample_valid ? above_now : above_held;
    next_above_held = above;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      above_held <= 3'b000;
    end else begin
      above_held <= next_above_held;
    end
  end

  // ==========================================================
  // tap sequencer over all axes together
  typedef enum logic [2:0] {
    TDC_IDLE, TDC_PULSE1, TDC_LAT, TDC_WIN, TDC_PULSE2, TDC_QUIET
  } tdc_state_t;

  tdc_state_t state;
  tdc_state_t next_state;
  logic [7:0] tmr;
  logic [7:0] next_tmr;
  logic [7:0] ltmr;
  logic [7:0] next_ltmr;
  logic [2:0] axes;
  logic [2:0] next_axes;
  logic [2:0] sgn;
  logic [2:0] next_sgn;
  logic       suspend;
  logic       next_suspend;
  logic       det;
  logic       det_dbl;
  logic [2:0] sen;
  logic [2:0] den;
  logic       any_above;

  assign sen = {config_q[TDC_CFG_ZS], config_q[TDC_CFG_YS],
                config_q[TDC_CFG_XS]};
  assign den = {config_q[TDC_CFG_ZD], config_q[TDC_CFG_YD],
                config_q[TDC_CFG_XD]};
  assign any_above = |(above & (sen | den));

  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_ltmr = ltmr;
    next_axes = axes;
    next_sgn = sgn;
    next_suspend = suspend;
    det = 1'b0;
    det_dbl = 1'b0;
    unique case (state)
      TDC_IDLE: begin
        if (any_above) begin
          next_state = TDC_PULSE1;
          next_tmr = TDC_RST_BYTE;
          next_axes = above & (sen | den);
          next_sgn = neg;
        end
      end
      TDC_PULSE1: begin
        if (!any_above) begin
          next_state = TDC_LAT;
          next_ltmr = TDC_RST_BYTE;
          next_suspend = 1'b0;
          det = |(axes & sen);
        end else if (tick && tmr == time_limit) begin
          next_state = TDC_QUIET;
        end else if (tick) begin
          next_tmr = tmr + 8'h01;
        end
      end
      TDC_LAT: begin
        // pulses here are ignored, only watched for abort
        if (any_above && config_q[TDC_CFG_ABORT]) begin
          next_suspend = 1'b1;
        end
        if (tick && ltmr == latency) begin
          next_tmr = TDC_RST_BYTE;
          // abort only if the pulse ended in time
          if (!(|(axes & den)) || (suspend && !any_above)) begin
            next_state = TDC_IDLE;
          end else begin
            next_state = TDC_WIN;
          end
        end else if (tick) begin
          next_ltmr = ltmr + 8'h01;
        end
      end
      TDC_WIN: begin
        if (any_above) begin
          next_state = TDC_PULSE2;
          next_tmr = TDC_RST_BYTE;
          next_sgn = neg;
        end else if (tick && tmr == window) begin
          next_state = TDC_IDLE;
        end else if (tick) begin
          next_tmr = tmr + 8'h01;
        end
      end
      TDC_PULSE2: begin
        if (!any_above) begin
          next_state = TDC_IDLE;
          det = |(axes & den);
          det_dbl = 1'b1;
        end else if (tick && tmr == time_limit) begin
          next_state = TDC_QUIET;
        end else if (tick) begin
          next_tmr = tmr + 8'h01;
        end
      end
      TDC_QUIET: begin
        // the tail of an over-long pulse is no new threshold crossing
        if (!any_above) begin
          next_state = TDC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= TDC_IDLE;
      tmr <= TDC_RST_BYTE;
      ltmr <= TDC_RST_BYTE;
      axes <= 3'b000;
      sgn <= 3'b000;
      suspend <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      ltmr <= next_ltmr;
      axes <= next_axes;
      sgn <= next_sgn;
      suspend <= next_suspend;
    end
  end

  // ==========================================================
  // source register
  logic       active;
  logic       next_active;
  tdc_event_t evt;
  tdc_event_t next_evt;
  tdc_event_t found;
  logic       src_read;

  assign src_read = ap_rd && ap_idx == TDC_IDX_SOURCE;
  always_comb begin
    found.seen = axes & (det_dbl ? den : sen);
    found.double_tap = det_dbl;
    found.sign = sgn & found.seen;
  end

  always_comb begin
    next_active = active;
    next_evt = evt;
    if (src_read) begin
      next_active = 1'b0;
      next_evt = '0;
    end
    // a new event on the clearing read wins over the clear
    if (det) begin
      next_active = 1'b1;
      if (!(active && config_q[TDC_CFG_LATCH]) || src_read) begin
        next_evt = found;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active <= 1'b0;
      evt <= '0;
    end else begin
      active <= next_active;
      evt <= next_evt;
    end
  end

  assign tap_irq = active;

  // ==========================================================
  // read mux
  always_comb begin
    hrdata = 32'h0000_0000;
    if (ap_rd) begin
      unique case (ap_idx)
        TDC_IDX_CONFIG:  hrdata[7:0] = config_q;
        TDC_IDX_SOURCE:  hrdata[7:0] = {active, evt};
        TDC_IDX_LEVEL_X: hrdata[6:0] = level[TDC_AXIS_X];
        TDC_IDX_LEVEL_Y: hrdata[6:0] = level[TDC_AXIS_Y];
        TDC_IDX_LEVEL_Z: hrdata[6:0] = level[TDC_AXIS_Z];
        TDC_IDX_LIMIT:   hrdata[7:0] = time_limit;
        TDC_IDX_LATENCY: hrdata[7:0] = latency;
        TDC_IDX_WINDOW:  hrdata[7:0] = window;
        TDC_IDX_CONTROL: hrdata[7:0] = control;
        TDC_IDX_STEP:    hrdata[15:0] = step;
        default: ;
      endcase
    end
  end
endmodule

// file: tb/tdc_tap_detect_monitor.sv
`timescale 1ns/1ps
module tdc_tap_detect_monitor
  import tdc_pkg::*;
(
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [2:0]         hsize,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               sample_valid,
  input wire logic signed [13:0] accel_x,
  input wire logic signed [13:0] accel_y,
  input wire logic signed [13:0] accel_z,
  input wire logic               tap_irq
);
  logic       dph;
  logic       dwr;
  logic [7:0] didx;
  logic       src_rd;
  logic       lvl_rd;
  // ==========================================================
  // data phase tracker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph  <= 1'b0;
      dwr  <= 1'b0;
      didx <= 8'h00;
    end else if (hready) begin
      dph  <= hsel && htrans[1];
      dwr  <= hwrite;
      didx <= haddr[9:2];
    end
  end
  assign src_rd = dph && !dwr && didx == TDC_IDX_SOURCE;
  assign lvl_rd = dph && !dwr && didx >= TDC_IDX_LEVEL_X
                  && didx <= TDC_IDX_LEVEL_Z;
  // ==========================================================
  // checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence src_rd_s;
    src_rd;
  endsequence
  sequence cleared_s;
    !tap_irq ##1 1'b1;
  endsequence
  level_msb_a: assert property (lvl_rd |-> hrdata[7] == 1'b0)
    else $error("level bit 7 not zero");
  irq_mirror_a: assert property (src_rd_s |-> hrdata[7] == tap_irq)
    else $error("irq differs from active flag");
  src_clear_a: assert property (src_rd_s |=> cleared_s)
    else $error("source read left irq set");
  irq_holds_a: assert property (tap_irq && !src_rd |=> tap_irq)
    else $error("irq dropped without read");
  reset_quiet_a: assert property ($rose(hresetn) |-> !tap_irq)
    else $error("irq set after reset");
  irq_sample_a: assert property ($rose(tap_irq) |-> $past(sample_valid))
    else $error("irq rose without sample");
  src_idle_a: assert property (src_rd && !tap_irq |-> hrdata[7:0] == 8'h00)
    else $error("status bits without active flag");
  event_axis_a: assert property (src_rd && hrdata[7] |-> hrdata[6:4] != 3'h0)
    else $error("event without axis");
endmodule

// file: tb/test_tdc_tap_detect.sv
`timescale 1ns/1ps
module test_tdc_tap_detect;
  import tdc_pkg::*;
  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  logic               sample_valid;
  logic signed [13:0] acc [3];
  logic               tap_irq;
  int                 bad_count;
  int                 tests_run;
  int                 cycles;
  tdc_tap_detect uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_valid(sample_valid), .accel_x(acc[0]),
    .accel_y(acc[1]), .accel_z(acc[2]), .tap_irq(tap_irq)
  );
  always #5 hclk = ~hclk;
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, {24'h0, d}, rd);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    check(rd, {24'h0, exp});
  endtask
  task automatic tap(input int ax, input logic signed [13:0] v, input int n);
    @(posedge hclk);
    acc[ax] <= v;
    repeat (n) @(posedge hclk);
    acc[ax] <= 14'sh0;
  endtask
  // waits for an event, reads the source, then sees the irq gone
  task automatic probe(input logic [7:0] exp);
    for (int i = 0; i < 100 && tap_irq !== 1'b1; i++) @(posedge hclk);
    rdchk(TDC_IDX_SOURCE, exp);
    repeat (60) @(posedge hclk);
    check({31'h0, tap_irq}, 32'h0);
  endtask
  function automatic logic [7:0] src(input int ax, input bit neg,
                                     input bit dbl);
    logic [7:0] s;
    s = 8'h00;
    s[TDC_SRC_ACTIVE] = 1'b1;
    s[TDC_SRC_SEEN0 + ax] = 1'b1;
    s[TDC_SRC_DOUBLE] = dbl;
    s[TDC_SRC_SIGN0 + ax] = neg;
    return s;
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // hang guard, the whole run needs well under 10000 cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    sample_valid = 1'b0;
    acc = '{default: 14'sh0};
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    sample_valid <= 1'b1;
    for (int i = 'h21; i <= 'h25; i++) rdchk(8'(i), 8'h00);
    wr(8'h29, 8'hff);
    rdchk(8'h29, 8'h00);
    wr(TDC_IDX_CONFIG, 8'hff);
    rdchk(TDC_IDX_CONFIG, 8'hff);
    for (int a = 0; a < 3; a++) begin
      wr(8'(TDC_IDX_LEVEL_X + a), 8'hff);
      rdchk(8'(TDC_IDX_LEVEL_X + a), 8'h7f);
      wr(8'(TDC_IDX_LEVEL_X + a), 8'h10);
    end
    // one hclk per time step keeps the windows short
    wr(TDC_IDX_STEP, 8'h00);
    wr(TDC_IDX_LIMIT, 8'h10);
    wr(TDC_IDX_LATENCY, 8'h08);
    wr(TDC_IDX_WINDOW, 8'h30);
    for (int a = 0; a < 6; a++) begin
      wr(TDC_IDX_CONFIG, 8'(1 << (2 * (a % 3))));
      tap(a % 3, (a < 3) ? 14'sd2048 : -14'sd2048, 4);
      probe(src(a % 3, a >= 3, 1'b0));
    end
    wr(TDC_IDX_CONFIG, 8'h01);
    tap(2, 14'sd2048, 4);
    probe(8'h00);
    wr(TDC_IDX_CONFIG, 8'h02);
    tap(0, 14'sd2048, 4);
    probe(8'h00);
    wr(TDC_IDX_CONFIG, 8'h01);
    // no sample marked valid: the compare must not start a pulse
    sample_valid <= 1'b0;
    tap(0, 14'sd2048, 4);
    probe(8'h00);
    sample_valid <= 1'b1;
    for (int lv = 'h1f; lv <= 'h20; lv++) begin
      wr(TDC_IDX_LEVEL_X, 8'(lv));
      tap(0, 14'sd2048, 4);
      probe(lv == 'h1f ? src(0, 0, 0) : 8'h00);
    end
    wr(TDC_IDX_LEVEL_X, 8'h10);
    tap(0, 14'sd2048, 40);
    probe(8'h00);
    wr(TDC_IDX_LEVEL_X, 8'h7f);
    for (int ln = 0; ln < 2; ln++) begin
      wr(TDC_IDX_CONTROL, 8'(ln << TDC_CTL_LOW_NOISE));
      tap(0, 14'sd8191, 4);
      probe(ln == 1 ? src(0, 0, 0) : 8'h00);
    end
    wr(TDC_IDX_CONTROL, 8'h00);
    wr(TDC_IDX_LEVEL_X, 8'h10);
    // a short pulse inside the latency, then one in the window
    for (int ab = 0; ab < 2; ab++) begin
      wr(TDC_IDX_CONFIG, 8'((ab << TDC_CFG_ABORT) | 2));
      tap(0, 14'sd2048, 3);
      tap(0, 14'sd2048, 2);
      repeat (12) @(posedge hclk);
      tap(0, 14'sd2048, 3);
      probe(ab == 1 ? 8'h00 : src(0, 0, 1));
    end
    for (int le = 0; le < 2; le++) begin
      wr(TDC_IDX_CONFIG, 8'((le << TDC_CFG_LATCH) | 5));
      tap(0, 14'sd2048, 4);
      repeat (30) @(posedge hclk);
      tap(1, -14'sd2048, 4);
      probe(le == 1 ? src(0, 0, 0) : src(1, 1, 0));
    end
    complete_run();
  end
endmodule
bind tdc_tap_detect tdc_tap_detect_monitor mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .sample_valid(sample_valid), .accel_x(accel_x),
  .accel_y(accel_y), .accel_z(accel_z), .tap_irq(tap_irq)
);
